/* verilog/cso_framer.sv */
`timescale 1ns/1ps
`include "cso_params.svh"
// Function
// - Keep bits mark valid Dwords, contiguous from first descriptor to last payload Dword.
// - All keep bits high in every beat except a short last beat.
// - Keep behaviour ignores payload alignment mode, Dword or address aligned.
// - Keep bits above the bus width are tied low for 64 and 128 bits.
// - Straddle on 256 bits holds keep all ones; consumer uses sideband markers.
// - Valid is raised with valid data and held until accepted; it drops mid-packet if the FIFO runs empty.
// - A beat moves only when valid and ready are both high.
// - While valid and ready low, data and valid stay unchanged.
// - Byte enable i flags payload byte i; never set on descriptor bytes.
// - Payload byte enables of one TLP form one contiguous run.
// - Byte enables above the bus width are tied low for 64 and 128 bits.
// - Without straddle, first start marker in each TLP's first beat; one start per beat.
// - With straddle, first start is lane 0 unless prior TLP continues, then lane 16.
// - Second start at lane 16 only when prior TLP ended in bytes 0-15 same beat.
// - Second start marker is zero outside 256-bit straddle.
// - End marker and last Dword offset used only in 256-bit straddle.
// - In straddle mode TLPs are not framed as stream packets.
// - End of packet marks last beat without straddle, always zero with straddle.
module cso_framer
  import cso_pkg::*;
#(
  parameter int DATA_W = 256,
  parameter bit STRADDLE = 1'b0,
  parameter int FIFO_DEPTH = `CSO_FIFO_DEPTH
)(
  input logic clk,
  input logic rst,
  input cso_seg_s seg_in,
  input logic seg_in_valid,
  output logic seg_in_ready,
  output logic [`CSO_BUS_W-1:0] completion_out_bus,
  output logic [`CSO_KEEP_W-1:0] completion_dword_keep,
  output logic [`CSO_SB_W-1:0] completion_sideband,
  output logic completion_packet_end,
  output logic completion_out_valid,
  input logic [`CSO_READY_W-1:0] completion_out_ready
);

  function automatic logic [`CSO_KEEP_W-1:0] dw_mask(input logic [`CSO_NDW_W-1:0] n);
    logic [`CSO_KEEP_W:0] m;
    m = ({{`CSO_KEEP_W{1'b0}}, 1'b1} << n) - 1'b1;
    return m[`CSO_KEEP_W-1:0];
  endfunction

  function automatic logic [`CSO_BE_W-1:0] byte_mask(input logic [`CSO_KEEP_W-1:0] k);
    logic [`CSO_BE_W-1:0] b;
    b = '0;
    for (int i = 0; i < `CSO_KEEP_W; i++)
    begin
      b[4*i +: 4] = {4{k[i]}};
    end
    return b;
  endfunction

  function automatic logic [`CSO_BUS_W-1:0] bit_mask(input logic [`CSO_BE_W-1:0] b);
    logic [`CSO_BUS_W-1:0] d;
    d = '0;
    for (int i = 0; i < `CSO_BE_W; i++)
    begin
      d[8*i +: 8] = {8{b[i]}};
    end
    return d;
  endfunction

  localparam logic [`CSO_NDW_W-1:0] BUS_DW = `CSO_NDW_W'(DATA_W / 32);
  localparam logic [`CSO_KEEP_W-1:0] BUS_KEEP = dw_mask(BUS_DW);
  localparam logic [`CSO_NDW_W-1:0] HALF_DW = `CSO_NDW_W'(`CSO_HALF_DW);
  // Straddle only exists on the widest bus
  localparam bit STR_ON = STRADDLE && (DATA_W == `CSO_BUS_W);

  // Trims an incoming segment to the bus width and strips enables off
  // descriptor Dwords, so every later stage carries clean enables.
  function automatic cso_seg_s clean_seg(input cso_seg_s s);
    cso_seg_s c;
    logic [`CSO_KEEP_W-1:0] k;
    c = s;
    k = dw_mask(s.ndw) & BUS_KEEP;
    if (s.sof)
    begin
      k = k & ~`CSO_DESC_KEEP;
    end
    // Masking a contiguous run by an interval keeps it contiguous
    c.be = s.be & byte_mask(k);
    c.dat = s.dat & bit_mask(byte_mask(BUS_KEEP));
    return c;
  endfunction

  function automatic cso_beat_s plain_beat(input cso_seg_s s);
    cso_beat_s b;
    b = '0;
    b.dat = s.dat;
    // Derived from length alone, so alignment mode has no effect
    b.keep = dw_mask(s.ndw) & BUS_KEEP;
    b.side.be = s.be;
    b.side.sof0 = s.sof;
    b.last = s.eof;
    return b;
  endfunction

  function automatic cso_beat_s str_beat(
    input logic [`CSO_BUS_W-1:0] d,
    input logic [`CSO_BE_W-1:0] be,
    input logic s0,
    input logic s1,
    input logic e0,
    input logic [`CSO_OFF_W-1:0] off
  );
    cso_beat_s b;
    b = '0;
    b.dat = d;
    b.keep = `CSO_KEEP_ALL;
    b.side.be = be;
    b.side.sof0 = s0;
    b.side.sof1 = s1;
    b.side.eof0 = {off & {`CSO_OFF_W{e0}}, e0};
    b.last = 1'b0;
    return b;
  endfunction

  function automatic cso_half_s upper_half(input cso_seg_s s);
    cso_half_s h;
    h.dat = s.dat[`CSO_BUS_W-1:`CSO_HALF_W];
    h.be = s.be[`CSO_BE_W-1:`CSO_HALF_BE];
    h.ndw = `CSO_OFF_W'(s.ndw - HALF_DW);
    h.sof = 1'b0;
    h.eof = s.eof;
    return h;
  endfunction

  function automatic cso_half_s lower_half(input cso_seg_s s);
    cso_half_s h;
    h.dat = s.dat[`CSO_HALF_W-1:0];
    h.be = s.be[`CSO_HALF_BE-1:0];
    h.ndw = `CSO_OFF_W'(s.ndw);
    h.sof = s.sof;
    h.eof = s.eof;
    return h;
  endfunction

  cso_frm_s st_q;
  cso_frm_s st_d;
  cso_seg_s in_clean;
  cso_seg_s f_seg;
  logic f_v;
  logic pop;
  logic rdy;
  logic take;
  logic f_small;

  assign in_clean = clean_seg(seg_in);
  // Uniform drive lets any bit stand for all; demand all for safety
  assign rdy = &completion_out_ready;
  // Output register may be refilled only once empty or accepted
  assign take = !st_q.ov || rdy;
  assign f_small = f_seg.eof && (f_seg.ndw <= HALF_DW);

  cso_fifo #(
    .WIDTH($bits(cso_seg_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(in_clean),
    .in_valid(seg_in_valid),
    .in_ready(seg_in_ready),
    .out_data(f_seg),
    .out_valid(f_v),
    .out_ready(pop)
  );

  // Straddle keeps the tail of a TLP that lands in the low half as a
  // pending half beat, so the next TLP can start in lane 16 beside it.
  // A TLP that starts in lane 16 stays shifted by four Dwords to its end.
  always_comb
  begin
    st_d = st_q;
    pop = 1'b0;
    if (st_q.ov && rdy)
    begin
      st_d.ov = 1'b0;
    end
    if (take && !STR_ON)
    begin
      if (f_v)
      begin
        st_d.ov = 1'b1;
        st_d.beat = plain_beat(f_seg);
        pop = 1'b1;
      end
    end
    else if (take && !st_q.pv)
    begin
      if (f_v)
      begin
        pop = 1'b1;
        if (f_small)
        begin
          // Held back one beat in case another TLP can share it
          st_d.pv = 1'b1;
          st_d.part = lower_half(f_seg);
        end
        else
        begin
          st_d.ov = 1'b1;
          st_d.beat = str_beat(f_seg.dat, f_seg.be, f_seg.sof, 1'b0,
                               f_seg.eof, `CSO_OFF_W'(f_seg.ndw - 1'b1));
        end
      end
    end
    else if (take && st_q.part.eof)
    begin
      // A second TLP ending in the same beat is never formed
      if (f_v && f_seg.sof && !f_small)
      begin
        pop = 1'b1;
        st_d.ov = 1'b1;
        st_d.beat = str_beat({f_seg.dat[`CSO_HALF_W-1:0], st_q.part.dat},
                             {f_seg.be[`CSO_HALF_BE-1:0], st_q.part.be},
                             1'b1, st_q.part.sof, 1'b1,
                             st_q.part.ndw - 1'b1);
        st_d.part = upper_half(f_seg);
      end
      else
      begin
        // Sent alone rather than stall a finished TLP
        st_d.ov = 1'b1;
        st_d.pv = 1'b0;
        st_d.beat = str_beat({{`CSO_HALF_W{1'b0}}, st_q.part.dat},
                             {{`CSO_HALF_BE{1'b0}}, st_q.part.be},
                             st_q.part.sof, 1'b0, 1'b1,
                             st_q.part.ndw - 1'b1);
      end
    end
    else if (take && f_v)
    begin
      // Continuation of a TLP shifted into lane 16
      pop = 1'b1;
      st_d.ov = 1'b1;
      st_d.beat = str_beat({f_seg.dat[`CSO_HALF_W-1:0], st_q.part.dat},
                           {f_seg.be[`CSO_HALF_BE-1:0], st_q.part.be},
                           1'b0, 1'b0, f_small,
                           `CSO_OFF_W'(f_seg.ndw + HALF_DW - 1'b1));
      if (f_small)
      begin
        st_d.pv = 1'b0;
      end
      else
      begin
        st_d.part = upper_half(f_seg);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= '0;
      if (STR_ON)
      begin
        st_q.beat.keep <= `CSO_KEEP_ALL;
      end
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign completion_out_valid = st_q.ov;
  assign completion_out_bus = st_q.beat.dat;
  assign completion_dword_keep = st_q.beat.keep;
  assign completion_sideband = st_q.beat.side;
  assign completion_packet_end = st_q.beat.last;

endmodule // cso_framer

/* verilog/cso_params.svh */
`ifndef CSO_PARAMS_SVH
`define CSO_PARAMS_SVH
`define CSO_BUS_W 256
`define CSO_BUS_DW 8
`define CSO_KEEP_W 8
`define CSO_BE_W 32
`define CSO_HALF_W 128
`define CSO_HALF_BE 16
`define CSO_HALF_DW 4
`define CSO_NDW_W 4
`define CSO_OFF_W 3
`define CSO_DESC_KEEP 8'h07
`define CSO_KEEP_ALL 8'hff
`define CSO_READY_W 22
`define CSO_FIFO_DEPTH 16
`define CSO_SB_W 38
`endif

/* verilog/cso_pkg.sv */
package cso_pkg;
`include "cso_params.svh"

  // One bus-wide segment of a single TLP, data in lane 0 upward
  typedef struct packed {
    logic [`CSO_BUS_W-1:0] dat;
    logic [`CSO_BE_W-1:0] be;
    logic [`CSO_NDW_W-1:0] ndw;
    logic sof;
    logic eof;
  } cso_seg_s;

  typedef struct packed {
    logic [`CSO_HALF_W-1:0] dat;
    logic [`CSO_HALF_BE-1:0] be;
    logic [`CSO_OFF_W-1:0] ndw;
    logic sof;
    logic eof;
  } cso_half_s;

  // Packed so that eof0 sits at 37:34, sof1 at 33, sof0 at 32
  typedef struct packed {
    logic [`CSO_OFF_W:0] eof0;
    logic sof1;
    logic sof0;
    logic [`CSO_BE_W-1:0] be;
  } cso_side_s;

  typedef struct packed {
    logic [`CSO_BUS_W-1:0] dat;
    logic [`CSO_KEEP_W-1:0] keep;
    cso_side_s side;
    logic last;
  } cso_beat_s;

  typedef struct packed {
    logic ov;
    cso_beat_s beat;
    logic pv;
    cso_half_s part;
  } cso_frm_s;
endpackage

/* verilog/cso_mem.sv */
`timescale 1ns/1ps
module cso_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
)(
  input logic clk,
  input logic we,
  input logic [AW-1:0] waddr,
  input logic [WIDTH-1:0] wdata,
  input logic re,
  input logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] store [DEPTH];

  // No reset on the array; only read data that was written is used
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      store[waddr] <= wdata;
    end
    if (re)
    begin
      rdata <= store[raddr];
    end
  end
endmodule // cso_mem

/* verilog/cso_fifo.sv */
`timescale 1ns/1ps
module cso_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)(
  input logic clk,
  input logic rst,
  input logic [WIDTH-1:0] in_data,
  input logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input logic out_ready
);
  // DEPTH must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
  } cso_fifo_st_s;

  cso_fifo_st_s st_q;
  cso_fifo_st_s st_d;
  logic push;
  logic rd_go;

  assign in_ready = (st_q.cnt != FULL_CNT);
  assign push = in_valid && in_ready;
  // Read ahead into the output register whenever it frees up
  assign rd_go = (st_q.cnt != '0) && (!st_q.ov || out_ready);
  assign out_valid = st_q.ov;

  always_comb
  begin
    st_d = st_q;
    if (push)
    begin
      st_d.wp = st_q.wp + 1'b1;
    end
    if (rd_go)
    begin
      st_d.rp = st_q.rp + 1'b1;
      st_d.ov = 1'b1;
    end
    else if (out_ready)
    begin
      st_d.ov = 1'b0;
    end
    if (push && !rd_go)
    begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
    else if (!push && rd_go)
    begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  cso_mem #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk(clk),
    .we(push),
    .waddr(st_q.wp),
    .wdata(in_data),
    .re(rd_go),
    .raddr(st_q.rp),
    .rdata(out_data)
  );
endmodule // cso_fifo

/* tb/cso_framer_checker.sv */
`timescale 1ns/1ps
`include "cso_params.svh"
module cso_framer_checker
  import cso_pkg::*;
#(
  parameter int DATA_W = 256,
  parameter bit STRADDLE = 1'b0,
  parameter int FIFO_DEPTH = `CSO_FIFO_DEPTH
)(
  input logic clk,
  input logic rst,
  input cso_seg_s seg_in,
  input logic seg_in_valid,
  input logic seg_in_ready,
  input logic [`CSO_BUS_W-1:0] completion_out_bus,
  input logic [`CSO_KEEP_W-1:0] completion_dword_keep,
  input logic [`CSO_SB_W-1:0] completion_sideband,
  input logic completion_packet_end,
  input logic completion_out_valid,
  input logic [`CSO_READY_W-1:0] completion_out_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic ov, acc, pe;
  logic [7:0] kp;
  logic [31:0] be, km;
  assign ov = completion_out_valid;
  assign acc = ov && &completion_out_ready;
  assign pe = completion_packet_end;
  assign kp = completion_dword_keep;
  assign be = completion_sideband[31:0];
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      km[i*4 +: 4] = {4{kp[i]}};
  end
  property p_hold;
    ov && !(&completion_out_ready) |=> ov
      && $stable({completion_out_bus, completion_sideband, kp, pe});
  endproperty
  a_hold: assert property (p_hold) else $error("beat moved while stalled");
  property p_keep_run;
    ov |-> kp != 8'h00 && (kp & (kp + 8'h01)) == 8'h00;
  endproperty
  a_keep_run: assert property (p_keep_run) else $error("keep not contiguous");
  property p_keep_full;
    ov && (!pe || STRADDLE) |-> kp == 8'hff;
  endproperty
  a_keep_full: assert property (p_keep_full) else $error("keep short mid packet");
  property p_be_run;
    ov && be != 32'h0 |-> (((be | (be - 32'h1)) + 32'h1) & be) == 32'h0;
  endproperty
  a_be_run: assert property (p_be_run) else $error("byte enables split");
  property p_be_desc;
    ov |-> (be & ~km) == 32'h0 && !(completion_sideband[32] && !STRADDLE && be[11:0] != 0);
  endproperty
  a_be_desc: assert property (p_be_desc) else $error("enable on descriptor");
  property p_sof1;
    completion_sideband[33] |-> STRADDLE && DATA_W == 256 && completion_sideband[34];
  endproperty
  a_sof1: assert property (p_sof1) else $error("bad second start");
  property p_eof0;
    !STRADDLE |-> completion_sideband[37:34] == 4'h0;
  endproperty
  a_eof0: assert property (p_eof0) else $error("end offset outside straddle");
  property p_last;
    STRADDLE |-> !pe;
  endproperty
  a_last: assert property (p_last) else $error("packet end in straddle");
  property p_frame;
    acc && !STRADDLE |=> !ov || completion_sideband[32] == $past(pe);
  endproperty
  a_frame: assert property (p_frame) else $error("start marker misplaced");
  c_stall: cover property (ov && !(&completion_out_ready));
  c_multi: cover property (acc && !pe);
  c_full: cover property (!seg_in_ready);
  c_straddle: cover property (ov && completion_sideband[33]);
endmodule // cso_framer_checker
bind cso_framer cso_framer_checker #(.DATA_W(DATA_W), .STRADDLE(STRADDLE),
  .FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk(clk), .rst(rst), .seg_in(seg_in),
  .seg_in_valid(seg_in_valid), .seg_in_ready(seg_in_ready),
  .completion_out_bus(completion_out_bus), .completion_dword_keep(completion_dword_keep),
  .completion_sideband(completion_sideband), .completion_packet_end(completion_packet_end),
  .completion_out_valid(completion_out_valid), .completion_out_ready(completion_out_ready));

/* tb/cso_consumer.sv */
`timescale 1ns/1ps
module cso_consumer (
  input logic clk,
  input logic [1:0] mode,
  output logic [21:0] ready
);
  logic ph_q = 1'b0;
  initial ready = '0;
  // All bits move together
  always @(posedge clk)
  begin
    ph_q <= ~ph_q;
    case (mode)
      2'h0: ready <= '1;
      2'h1: ready <= {22{ph_q}};
      default: ready <= '0;
    endcase
  end
endmodule // cso_consumer

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench
  import cso_pkg::*;
;
  logic clk, rst, siv, sir, ov, pe;
  cso_seg_s si;
  logic [255:0] bus;
  logic [7:0] kp;
  logic [37:0] sb;
  logic [21:0] rdy;
  logic [1:0] mode;
  logic str_iv, str_ir, str_ov, str_pe;
  cso_seg_s str_in;
  logic [255:0] str_bus;
  logic [7:0] str_kp;
  logic [37:0] str_sb;
  int n_mismatch, checks_done;
  cso_beat_s q[$];
  cso_framer dut (.clk(clk), .rst(rst), .seg_in(si), .seg_in_valid(siv), .seg_in_ready(sir),
    .completion_out_bus(bus), .completion_dword_keep(kp), .completion_sideband(sb),
    .completion_packet_end(pe), .completion_out_valid(ov), .completion_out_ready(rdy));
  cso_consumer u_con (.clk(clk), .mode(mode), .ready(rdy));
  // Straddle needs its own instance; the straddle option is fixed at build time
  cso_framer #(.STRADDLE(1'b1)) dut_str (.clk(clk), .rst(rst), .seg_in(str_in),
    .seg_in_valid(str_iv), .seg_in_ready(str_ir), .completion_out_bus(str_bus),
    .completion_dword_keep(str_kp), .completion_sideband(str_sb),
    .completion_packet_end(str_pe), .completion_out_valid(str_ov), .completion_out_ready(rdy));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
    checks_done++;
    if (e !== g)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [255:0] dm(input logic [7:0] k);
    dm = '0;
    for (int i = 0; i < 8; i++)
      dm[i*32 +: 32] = {32{k[i]}};
  endfunction
  always @(posedge clk)
  begin
    cso_beat_s e;
    if (!rst && ov === 1'b1 && &rdy)
    begin
      chk("beat expected", 1, q.size() > 0);
      e = '0;
      if (q.size() > 0)
        e = q.pop_front();
      chk("keep", e.keep, kp);
      chk("data", e.dat & dm(e.keep), bus & dm(e.keep));
      chk("byte enables", e.side.be, sb[31:0]);
      chk("start", e.side.sof0, sb[32]);
      chk("end", e.last, pe);
      chk("straddle bits", 0, sb[37:33]);
    end
  end
  // Source always offers every byte; the block must strip descriptor bytes
  task automatic push(input logic [3:0] n, input logic s, input logic e, input logic [31:0] v);
    cso_beat_s b;
    logic r;
    b = '0;
    for (int i = 0; i < 8; i++)
      if (i < n && !(s && i < 3))
        b.side.be[i*4 +: 4] = 4'hf;
    b.dat = {8{v}};
    b.keep = 8'hff >> (8 - n);
    b.side.sof0 = s;
    b.last = e;
    q.push_back(b);
    si <= '{dat: {8{v}}, be: '1, ndw: n, sof: s, eof: e};
    siv <= 1'b1;
    do
    begin
      @(negedge clk);
      r = sir;
      @(posedge clk);
    end while (!r);
  endtask
  task automatic drain(input string nm);
    siv <= 1'b0;
    for (int i = 0; i < 300 && q.size() > 0; i++)
      @(posedge clk);
    chk("beats left", 0, q.size());
    $display("test %s done", nm);
  endtask
  task automatic t_single;
    mode <= 2'h0;
    push(4'h8, 1'b1, 1'b1, 32'ha0);
    drain("single");
  endtask
  task automatic t_stall;
    mode <= 2'h1;
    push(4'h8, 1'b1, 1'b0, 32'hb0);
    push(4'h8, 1'b0, 1'b0, 32'hb1);
    push(4'h5, 1'b0, 1'b1, 32'hb2);
    push(4'h3, 1'b1, 1'b1, 32'hb3);
    drain("stall");
  endtask
  task automatic t_fill;
    mode <= 2'h2;
    // Output stage, FIFO head and 16 memory words all fill before ready drops
    for (int i = 0; i < 18; i++)
      push(i < 17 ? 4'h8 : 4'h2, i == 0, i == 17, 32'(i));
    siv <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("in ready full", 0, sir);
    @(posedge clk);
    mode <= 2'h0;
    drain("fill");
    chk("in ready empty", 1, sir);
  endtask
  // Short TLP A in lanes 0-15 shares its beat with the start of TLP B
  task automatic t_straddle;
    logic [255:0] a, b;
    logic r;
    a = {8{32'hc0}};
    b = {8{32'hc1}};
    mode <= 2'h0;
    str_iv <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      str_in <= '{dat: k ? b : a, be: '1, ndw: k ? 4'h8 : 4'h3, sof: 1'b1, eof: 1'b1};
      do
      begin
        @(negedge clk);
        r = str_ir;
        @(posedge clk);
      end while (!r);
    end
    str_iv <= 1'b0;
    for (int i = 0; i < 20 && !(str_ov === 1'b1 && &rdy); i++)
      @(negedge clk);
    chk("straddle beat", 1, str_ov);
    chk("straddle keep", 8'hff, str_kp);
    chk("straddle data", {b[127:0], a[127:0]}, str_bus);
    chk("straddle enables", 32'hf0000000, str_sb[31:0]);
    chk("straddle starts", 2'h3, str_sb[33:32]);
    chk("straddle end one", 4'h5, str_sb[37:34]);
    chk("straddle packet end", 0, str_pe);
    @(posedge clk);
    @(negedge clk);
    chk("straddle tail", 1, str_ov && &rdy);
    chk("straddle keep", 8'hff, str_kp);
    chk("straddle data", b[127:0], str_bus[127:0]);
    chk("straddle enables", 32'h0000ffff, str_sb[31:0]);
    chk("straddle starts", 0, str_sb[33:32]);
    chk("straddle end two", 4'h7, str_sb[37:34]);
    chk("straddle packet end", 0, str_pe);
    $display("test straddle done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    siv = 1'b0;
    si = '0;
    str_iv = 1'b0;
    str_in = '0;
    mode = 2'h2;
    n_mismatch = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset valid", 0, ov);
    @(posedge clk);
    t_single;
    t_stall;
    t_fill;
    t_straddle;
    complete_run;
  end
  // Whole run needs under a hundred cycles
  initial
  begin
    #20000;
    n_mismatch++;
    complete_run;
  end
endmodule // testbench
